/* File: hdl/sbs_consts.vh */
// Constants for the slip buffer status block: register offsets, bit positions, reset values.
// Included by the top design file of the block, the checker and the bench; definitions only.
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH

`define SBS_ADDR_W 16
`define SBS_STATUS_ADDR 16'h0b08
`define SBS_MASK_ADDR 16'h0b09
`define SBS_CTRL_ADDR 16'h0b0a

`define SBS_TX_FULL_BIT 7
`define SBS_TX_EMPTY_BIT 6
`define SBS_TX_SLIP_BIT 5
`define SBS_CAS_LOCK_BIT 4
`define SBS_CRC_LOCK_BIT 3
`define SBS_RX_FULL_BIT 2
`define SBS_RX_EMPTY_BIT 1
`define SBS_RX_SLIP_BIT 0

`define SBS_CTRL_CAS_EN_BIT 0
`define SBS_CTRL_CRC_EN_BIT 1
`define SBS_CTRL_LOSS_LSB 2
`define SBS_CTRL_LOSS_MSB 5

`define SBS_STATUS_RESET 8'h00
`define SBS_MASK_RESET 8'h00
`define SBS_CTRL_RESET 8'h0b
`define SBS_STICKY_MASK 8'he7

`define SBS_FRAME_WORDS 32
`define SBS_BUF_ADDR_W 6

`endif

/* File: hdl/sbs_frame_ram.v */
// Simple dual-port storage for one elastic store; read data come out of a register.
// Assumes one clock for both ports; a read of the address being written returns old data.
`timescale 1ns/100ps
module sbs_frame_ram #(
    parameter DATA_W = 8,
    parameter ADDR_W = 6
) (
    input wire clk,
    input wire ce,
    input wire wrEn,
    input wire [ADDR_W-1:0] wrAddr,
    input wire [DATA_W-1:0] wrData,
    input wire rdEn,
    input wire [ADDR_W-1:0] rdAddr,
    output reg [DATA_W-1:0] rdData
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // No reset on the array so it maps onto block memory
    always @(posedge clk) begin
        if (ce && wrEn) begin
            mem[wrAddr] <= wrData;
        end
        if (ce && rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

/* File: hdl/sbs_elastic.v */
// Two-frame elastic store with controlled slips: frame deletion on overflow, replay on underflow.
// Assumes writer and reader share clk; the depth must be exactly two frames.
`timescale 1ns/100ps
module sbs_elastic #(
    parameter DATA_W = 8,
    parameter FRAME_WORDS = 32,
    parameter ADDR_W = 6
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire wrEn,
    input wire [DATA_W-1:0] wrData,
    input wire rdEn,
    output wire [DATA_W-1:0] rdData,
    output reg overflowEvt,
    output reg underflowEvt
);
    localparam [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};
    localparam [ADDR_W:0] FRAME_CNT = FRAME_WORDS[ADDR_W:0];
    localparam [ADDR_W-1:0] FRAME_OFF = FRAME_WORDS[ADDR_W-1:0];

    reg [ADDR_W-1:0] wrPtr_r;
    reg [ADDR_W-1:0] rdPtr_r;
    reg [ADDR_W:0] count_r;
    reg [ADDR_W-1:0] rdBase;
    reg [ADDR_W:0] count_nxt;
    reg ovf;
    reg unf;

    always @* begin
        rdBase = rdPtr_r;
        count_nxt = count_r;
        ovf = 1'b0;
        unf = 1'b0;
        // Full and written: drop the oldest whole frame to make room
        if (wrEn && count_r == DEPTH) begin
            rdBase = rdPtr_r + FRAME_OFF;
            count_nxt = count_r - FRAME_CNT;
            ovf = 1'b1;
        end
        // Empty and read: step back one frame so the last frame is replayed
        if (rdEn && count_r == {(ADDR_W+1){1'b0}}) begin
            rdBase = rdPtr_r - FRAME_OFF;
            count_nxt = count_nxt + FRAME_CNT;
            unf = 1'b1;
        end
        if (wrEn) begin
            count_nxt = count_nxt + 1'b1;
        end
        if (rdEn) begin
            count_nxt = count_nxt - 1'b1;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_r <= {ADDR_W{1'b0}};
            rdPtr_r <= {ADDR_W{1'b0}};
            count_r <= {(ADDR_W+1){1'b0}};
            overflowEvt <= 1'b0;
            underflowEvt <= 1'b0;
        end else if (ce) begin
            if (wrEn) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            rdPtr_r <= rdEn ? rdBase + 1'b1 : rdBase;
            count_r <= count_nxt;
            overflowEvt <= ovf;
            underflowEvt <= unf;
        end
    end

    sbs_frame_ram #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) uRam (
        .clk(clk),
        .ce(ce),
        .wrEn(wrEn),
        .wrAddr(wrPtr_r),
        .wrData(wrData),
        .rdEn(rdEn),
        .rdAddr(rdBase),
        .rdData(rdData)
    );
endmodule

/* File: hdl/sbs_slip_status.v */
// Summary of operation
// - Transmit store full and written: delete one frame, set bit 7.
// - Transmit store empty and read: replay one frame, set bit 6.
// - Any transmit slip sets bit 5.
// - Slip flags stay set until the status register is read, which clears them, or a one is written to them.
// - Receive store full and written: delete one frame, set bit 2.
// - Bit 4 shows current CAS multiframe lock, read only.
// - CAS lock lost after programmable count of consecutive errored alignment signals.
// - Bit 3 shows CRC multiframe lock from framer declare and loss criteria.
// - Lock bits are meaningless while CAS or CRC multiframing is disabled.
// - Receive store empty and read: replay one frame, set bit 1.
// - Any receive slip sets bit 0.
//
// Top of the slip buffer status block: two elastic stores, sticky status, mask, lock state.
// Assumes all inputs are synchronous to clk and strobes last one cycle.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "sbs_consts.vh"
module sbs_slip_status #(
    parameter DATA_W = 8,
    parameter FRAME_WORDS = `SBS_FRAME_WORDS,
    parameter BUF_ADDR_W = `SBS_BUF_ADDR_W
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [`SBS_ADDR_W-1:0] busAddr,
    input wire [7:0] busWrData,
    input wire busWrEn,
    input wire busRdEn,
    output reg [7:0] busRdData,
    input wire txWrEn,
    input wire [DATA_W-1:0] txWrData,
    input wire txRdEn,
    output wire [DATA_W-1:0] txRdData,
    input wire rxWrEn,
    input wire [DATA_W-1:0] rxWrData,
    input wire rxRdEn,
    output wire [DATA_W-1:0] rxRdData,
    input wire casMfasGood,
    input wire casMfasBad,
    input wire crcLockDeclare,
    input wire crcLockLoss,
    output reg irq
);
    reg [7:0] status_r;
    reg [7:0] status_nxt;
    reg [7:0] mask_r;
    reg [7:0] ctrl_r;
    reg casLock_r;
    reg crcLock_r;
    reg [3:0] casErrCnt_r;
    reg [7:0] events;
    reg [7:0] readVal;
    wire txOvf;
    wire txUnf;
    wire rxOvf;
    wire rxUnf;
    wire casEnable;
    wire crcEnable;
    wire [3:0] lossCount;
    wire statusRd;
    wire statusWr;

    assign casEnable = ctrl_r[`SBS_CTRL_CAS_EN_BIT];
    assign crcEnable = ctrl_r[`SBS_CTRL_CRC_EN_BIT];
    assign lossCount = ctrl_r[`SBS_CTRL_LOSS_MSB:`SBS_CTRL_LOSS_LSB];
    assign statusRd = busRdEn && busAddr == `SBS_STATUS_ADDR;
    assign statusWr = busWrEn && busAddr == `SBS_STATUS_ADDR;

    // Transmit store; slip detection and frame delete or replay inside
    sbs_elastic #(
        .DATA_W(DATA_W),
        .FRAME_WORDS(FRAME_WORDS),
        .ADDR_W(BUF_ADDR_W)
    ) uTxStore (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wrEn(txWrEn),
        .wrData(txWrData),
        .rdEn(txRdEn),
        .rdData(txRdData),
        .overflowEvt(txOvf),
        .underflowEvt(txUnf)
    );

    // Receive store
    sbs_elastic #(
        .DATA_W(DATA_W),
        .FRAME_WORDS(FRAME_WORDS),
        .ADDR_W(BUF_ADDR_W)
    ) uRxStore (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wrEn(rxWrEn),
        .wrData(rxWrData),
        .rdEn(rxRdEn),
        .rdData(rxRdData),
        .overflowEvt(rxOvf),
        .underflowEvt(rxUnf)
    );

    always @* begin
        events = 8'h00;
        events[`SBS_TX_FULL_BIT] = txOvf;
        events[`SBS_TX_EMPTY_BIT] = txUnf;
        events[`SBS_TX_SLIP_BIT] = txOvf | txUnf;
        events[`SBS_RX_FULL_BIT] = rxOvf;
        events[`SBS_RX_EMPTY_BIT] = rxUnf;
        events[`SBS_RX_SLIP_BIT] = rxOvf | rxUnf;
        status_nxt = status_r;
        // Read clears every sticky bit; a write of one clears that bit too
        if (statusRd) begin
            status_nxt = 8'h00;
        end else if (statusWr) begin
            status_nxt = status_r & ~busWrData;
        end
        // Set wins over clear so an event during the read is kept
        status_nxt = (status_nxt | events) & `SBS_STICKY_MASK;
    end

    always @* begin
        readVal = 8'h00;
        if (busAddr == `SBS_STATUS_ADDR) begin
            readVal = status_r;
            readVal[`SBS_CAS_LOCK_BIT] = casLock_r;
            readVal[`SBS_CRC_LOCK_BIT] = crcLock_r;
        end else if (busAddr == `SBS_MASK_ADDR) begin
            readVal = mask_r;
        end else if (busAddr == `SBS_CTRL_ADDR) begin
            readVal = ctrl_r;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= `SBS_STATUS_RESET;
            mask_r <= `SBS_MASK_RESET;
            ctrl_r <= `SBS_CTRL_RESET;
            busRdData <= 8'h00;
            irq <= 1'b0;
        end else if (ce) begin
            status_r <= status_nxt;
            if (busWrEn && busAddr == `SBS_MASK_ADDR) begin
                mask_r <= busWrData & `SBS_STICKY_MASK;
            end
            if (busWrEn && busAddr == `SBS_CTRL_ADDR) begin
                ctrl_r <= busWrData;
            end
            // Read data stand only in the cycle after the strobe
            busRdData <= busRdEn ? readVal : 8'h00;
            irq <= |(status_nxt & mask_r);
        end
    end

    // CAS lock: gained on a good alignment signal, lost after lossCount errored ones in a row.
    // Held at zero while disabled, since the bit carries no meaning then.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            casLock_r <= 1'b0;
            casErrCnt_r <= 4'h0;
        end else if (ce) begin
            if (!casEnable) begin
                casLock_r <= 1'b0;
                casErrCnt_r <= 4'h0;
            end else if (casMfasGood) begin
                casLock_r <= 1'b1;
                casErrCnt_r <= 4'h0;
            end else if (casMfasBad && casLock_r) begin
                if (casErrCnt_r + 4'h1 >= lossCount) begin
                    casLock_r <= 1'b0;
                    casErrCnt_r <= 4'h0;
                end else begin
                    casErrCnt_r <= casErrCnt_r + 4'h1;
                end
            end
        end
    end

    // CRC lock follows the framer's declare and loss criteria; loss wins a tie
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crcLock_r <= 1'b0;
        end else if (ce) begin
            if (!crcEnable || crcLockLoss) begin
                crcLock_r <= 1'b0;
            end else if (crcLockDeclare) begin
                crcLock_r <= 1'b1;
            end
        end
    end
endmodule

/* File: verification/sbs_pcm_model.sv */
// PCM side of one elastic store: a writer and a reader, one word a cycle.
// Assumes the bench raises the go levels just after a clock edge.
`timescale 1ns/100ps
module sbs_pcm_model (
    input wire clk,
    input wire wrGo,
    input wire rdGo,
    output reg wrEn,
    output reg [7:0] wrData,
    output reg rdEn
);
    initial begin
        wrEn = 1'b0;
        wrData = 8'h00;
        rdEn = 1'b0;
    end
    // Running count as data, so that successive frames differ
    always @(posedge clk) begin
        wrEn <= wrGo;
        rdEn <= rdGo;
        wrData <= wrData + {7'h00, wrEn};
    end
endmodule

/* File: verification/sbs_slip_status_monitor.sv */
// Checker for the slip buffer status top; sees its ports only.
// Assumes ce stays high and the constants header is on the include path.
`timescale 1ns/100ps
`include "sbs_consts.vh"
module sbs_slip_status_mon (
    input wire clk,
    input wire rstn,
    input wire [`SBS_ADDR_W-1:0] busAddr,
    input wire [7:0] busWrData,
    input wire busWrEn,
    input wire busRdEn,
    input wire [7:0] busRdData,
    input wire txWrEn,
    input wire txRdEn,
    input wire rxWrEn,
    input wire rxRdEn,
    input wire casMfasGood,
    input wire casMfasBad,
    input wire crcLockDeclare,
    input wire crcLockLoss,
    input wire irq
);
    reg [7:0] maskR, ctrlR;
    reg [2:0] qS, qL;
    reg [3:0] bad;
    reg casX, crcX;
    wire [3:0] lim = (ctrlR[5:2] == 4'h0) ? 4'h0 : ctrlR[5:2] - 4'h1;
    wire rdSt = busRdEn && busAddr == `SBS_STATUS_ADDR;
    wire wrCt = busWrEn && busAddr == `SBS_CTRL_ADDR;
    wire lk = casMfasGood | casMfasBad | crcLockDeclare | crcLockLoss | wrCt;
    // Quiet counters keep the checks clear of events still in flight
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {maskR, ctrlR, qS, qL, bad, casX, crcX} <= {`SBS_MASK_RESET, `SBS_CTRL_RESET, 12'h000};
        end else begin
            if (busWrEn && busAddr == `SBS_MASK_ADDR) maskR <= busWrData & `SBS_STICKY_MASK;
            if (wrCt) ctrlR <= busWrData;
            qS <= (txWrEn | txRdEn | rxWrEn | rxRdEn) ? 3'h0 : qS + {2'h0, qS != 3'h7};
            qL <= lk ? 3'h0 : qL + {2'h0, qL != 3'h7};
            bad <= casMfasGood ? 4'h0 : bad + {3'h0, casMfasBad && bad != 4'hf};
            if (!ctrlR[`SBS_CTRL_CAS_EN_BIT] || casMfasBad && bad >= lim) casX <= 1'b0;
            else if (casMfasGood) casX <= 1'b1;
            if (!ctrlR[`SBS_CTRL_CRC_EN_BIT] || crcLockLoss) crcX <= 1'b0;
            else if (crcLockDeclare) crcX <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_idle; !busRdEn |=> busRdData == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data out of turn");
    property p_clr; rdSt ##2 rdSt && qS > 3'h4
        |=> (busRdData & `SBS_STICKY_MASK) == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("sticky bits survived a read");
    property p_unm; busRdEn && busAddr > `SBS_CTRL_ADDR |=> busRdData == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_msk; busRdEn && busAddr == `SBS_MASK_ADDR |=> busRdData == maskR; endproperty
    a_msk: assert property (p_msk) else $error("mask readback wrong");
    property p_ctl; busRdEn && wrCt == 1'b0 && busAddr == `SBS_CTRL_ADDR
        |=> busRdData == ctrlR; endproperty
    a_ctl: assert property (p_ctl) else $error("control readback wrong");
    property p_cas; rdSt && qL > 3'h2 |=> busRdData[`SBS_CAS_LOCK_BIT] == casX; endproperty
    a_cas: assert property (p_cas) else $error("CAS lock bit wrong");
    property p_crc; rdSt && qL > 3'h2 |=> busRdData[`SBS_CRC_LOCK_BIT] == crcX; endproperty
    a_crc: assert property (p_crc) else $error("CRC lock bit wrong");
    property p_irq; maskR == 8'h00 && $past(maskR) == 8'h00 |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq with all masked");
endmodule
bind sbs_slip_status sbs_slip_status_mon uMon (.clk(clk), .rstn(rstn), .busAddr(busAddr),
    .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn), .busRdData(busRdData),
    .txWrEn(txWrEn), .txRdEn(txRdEn), .rxWrEn(rxWrEn), .rxRdEn(rxRdEn), .irq(irq),
    .casMfasGood(casMfasGood), .casMfasBad(casMfasBad), .crcLockDeclare(crcLockDeclare),
    .crcLockLoss(crcLockLoss));

/* File: verification/sbs_slip_status_tb.sv */
// Bench for the slip buffer status block: registers, slips, interrupt, lock bits.
// Assumes the design, the PCM side model and the checker are compiled first.
`timescale 1ns/100ps
`include "sbs_consts.vh"
module sbs_slip_status_tb;
    localparam [15:0] ST = `SBS_STATUS_ADDR;
    reg clk, rstn, busWrEn, busRdEn;
    reg [15:0] busAddr;
    reg [7:0] busWrData;
    reg [3:0] go, lk;
    wire [7:0] busRdData, txWrData, rxWrData, txRdData, rxRdData;
    wire txWrEn, txRdEn, rxWrEn, rxRdEn, irq;
    integer failCount, checks;
    sbs_pcm_model txSide (.clk(clk), .wrGo(go[3]), .rdGo(go[2]), .wrEn(txWrEn),
        .wrData(txWrData), .rdEn(txRdEn));
    sbs_pcm_model rxSide (.clk(clk), .wrGo(go[1]), .rdGo(go[0]), .wrEn(rxWrEn),
        .wrData(rxWrData), .rdEn(rxRdEn));
    sbs_slip_status uut (.clk(clk), .rstn(rstn), .ce(1'b1), .busAddr(busAddr),
        .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn), .busRdData(busRdData),
        .txWrEn(txWrEn), .txWrData(txWrData), .txRdEn(txRdEn), .txRdData(txRdData),
        .rxWrEn(rxWrEn), .rxWrData(rxWrData), .rxRdEn(rxRdEn), .rxRdData(rxRdData),
        .casMfasGood(lk[3]), .casMfasBad(lk[2]), .crcLockDeclare(lk[1]),
        .crcLockLoss(lk[0]), .irq(irq));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                failCount = failCount + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        begin
            busAddr <= a;
            busWrData <= d;
            busWrEn <= 1'b1;
            @(posedge clk);
            busWrEn <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [15:0] a, input [7:0] exp);
        begin
            busAddr <= a;
            busRdEn <= 1'b1;
            @(posedge clk);
            busRdEn <= 1'b0;
            #1;
            chk(busRdData, exp);
            @(posedge clk);
        end
    endtask
    // Settled look at irq, txRdData or rxRdData, clear of the launching edge
    task ck(input [1:0] s, input [7:0] exp);
        begin
            #1;
            chk(s == 2'd0 ? {7'h00, irq} : s == 2'd1 ? txRdData : rxRdData, exp);
            @(posedge clk);
        end
    endtask
    // Long settle after each burst: flags land two cycles after the last strobe
    task run(input [3:0] sel, input integer n);
        begin
            go <= sel;
            repeat (n) @(posedge clk);
            go <= 4'h0;
            repeat (4) @(posedge clk);
        end
    endtask
    task pl(input [3:0] v);
        begin
            lk <= v;
            @(posedge clk);
            lk <= 4'h0;
            repeat (4) @(posedge clk);
        end
    endtask
    task tallyAndFinish;
        begin
            $display("checks %0d mismatches %0d", checks, failCount);
            if (failCount == 0 && checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {failCount, checks} = 64'h0;
        {rstn, busWrEn, busRdEn, busAddr, busWrData, go, lk} = 35'h0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(ST, 8'h00);
        rd(`SBS_MASK_ADDR, 8'h00);
        rd(`SBS_CTRL_ADDR, 8'h0b);
        rd(16'h0b0f, 8'h00);
        wr(`SBS_MASK_ADDR, 8'h80);
        // Words carry their write index: 65 writes fill two frames and force one deletion
        run(4'h8, 65);
        ck(2'd0, 8'h01);
        rd(ST, 8'ha0);
        rd(ST, 8'h00);
        ck(2'd0, 8'h00);
        // First frame deleted, so the oldest word left is index 32
        run(4'h4, 1);
        ck(2'd1, 8'h20);
        // Read 34 finds the store empty and replays from index 33; read 40 gives 39
        run(4'h4, 39);
        ck(2'd0, 8'h00);
        rd(ST, 8'h60);
        ck(2'd1, 8'h27);
        run(4'h2, 65);
        wr(ST, 8'h01);
        rd(ST, 8'h04);
        run(4'h1, 1);
        ck(2'd2, 8'h20);
        run(4'h1, 39);
        rd(ST, 8'h03);
        ck(2'd2, 8'h27);
        // 25 words left: read 26 underflows and its event meets the next status read
        go <= 4'h1;
        repeat (26) @(posedge clk);
        go <= 4'h0;
        @(posedge clk);
        rd(ST, 8'h00);
        rd(ST, 8'h03);
        pl(4'h8);
        pl(4'h4);
        rd(ST, 8'h10);
        pl(4'h4);
        rd(ST, 8'h00);
        pl(4'h2);
        rd(ST, 8'h08);
        pl(4'h1);
        rd(ST, 8'h00);
        wr(`SBS_CTRL_ADDR, 8'h08);
        pl(4'ha);
        rd(ST, 8'h00);
        tallyAndFinish;
    end
endmodule
